/* rtl/pdcr_regs.sv */
// Purpose : divider ratio and lock-detect phase registers of a two-stage pll
// Assumes : single clock, synchronous active-high reset, serial port pins synchronous
// Notes   : multi-byte ratios take effect byte by byte; an update pulse marks each write

`timescale 1ns/1ns

module pdcr_regs (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        spi_sclk_in,
  input  wire logic        spi_csn_in,
  input  wire logic        spi_sdio_in,
  output logic             spi_sdio_out,
  output logic             spi_sdio_oe_out,
  output logic [11:0]      main_feedback_ratio_out,
  output logic [8:0]       aux_feedback_ratio_out,
  output logic             aux_feedback_powerdown_out,
  output logic             aux_divider_enable_out,
  output logic [2:0]       feedback_sample_phase_out,
  output logic             feedback_bypass_select_out,
  output logic [11:0]      reference_prediv_ratio_out,
  output logic [2:0]       reference_sample_phase_out,
  output logic [8:0]       second_stage_ratio_out,
  output logic             first_stage_bypass_select_out,
  output logic [5:0]       second_stage_prediv_out,
  output logic             frequency_doubler_select_out,
  output logic             second_prediv_active_out,
  output logic             ratio_update_out
);

  // ---------------------------------------------------------------------------
  // serial port
  // ---------------------------------------------------------------------------
  logic       wr_en;
  logic [6:0] addr;
  logic [7:0] wr_data;
  logic [7:0] rd_data;

  pdcr_spi_port u_spi (
    .clk_in      (clk_in),
    .rst_in      (rst_in),
    .sclk_in     (spi_sclk_in),
    .csn_in      (spi_csn_in),
    .sdio_in     (spi_sdio_in),
    .rd_data_in  (rd_data),
    .sdio_out    (spi_sdio_out),
    .sdio_oe_out (spi_sdio_oe_out),
    .wr_en_out   (wr_en),
    .addr_out    (addr),
    .wr_data_out (wr_data)
  );

  // ---------------------------------------------------------------------------
  // next field values from the write strobe
  // ---------------------------------------------------------------------------
  logic [11:0] nxt_main_fb;
  logic [8:0]  nxt_aux_fb;
  logic        nxt_aux_pd;
  logic [2:0]  nxt_fb_phase;
  logic        nxt_fb_bypass;
  logic [11:0] nxt_ref_div;
  logic [2:0]  nxt_ref_phase;
  logic [8:0]  nxt_second;
  logic        nxt_first_bypass;
  logic [5:0]  nxt_prediv;
  logic        nxt_doubler;

  // address decode; reserved bits are simply not stored
  always_comb begin
    nxt_main_fb      = main_feedback_ratio_out;
    nxt_aux_fb       = aux_feedback_ratio_out;
    nxt_aux_pd       = aux_feedback_powerdown_out;
    nxt_fb_phase     = feedback_sample_phase_out;
    nxt_fb_bypass    = feedback_bypass_select_out;
    nxt_ref_div      = reference_prediv_ratio_out;
    nxt_ref_phase    = reference_sample_phase_out;
    nxt_second       = second_stage_ratio_out;
    nxt_first_bypass = first_stage_bypass_select_out;
    nxt_prediv       = second_stage_prediv_out;
    nxt_doubler      = frequency_doubler_select_out;
    if (wr_en) begin
      if (addr == pdcr_pkg::ADDR_FB_PHASE_PD_RATIO_HIGH) begin
        nxt_fb_phase      = wr_data[7:5];
        nxt_aux_pd        = wr_data[4];
        nxt_main_fb[11:8] = wr_data[3:0];
      end else if (addr == pdcr_pkg::ADDR_FB_RATIO_LOW) begin
        nxt_main_fb[7:0] = wr_data;
      end else if (addr == pdcr_pkg::ADDR_AUX_FB_RATIO_LOW) begin
        nxt_aux_fb[7:0] = wr_data;
      end else if (addr == pdcr_pkg::ADDR_AUX_FB_RATIO_TOP_BYPASS) begin
        nxt_aux_fb[8]  = wr_data[7];
        nxt_fb_bypass  = wr_data[0];
      end else if (addr == pdcr_pkg::ADDR_REF_PHASE_RATIO_HIGH) begin
        nxt_ref_phase     = wr_data[7:5];
        nxt_ref_div[11:8] = wr_data[3:0];
      end else if (addr == pdcr_pkg::ADDR_REF_RATIO_LOW) begin
        nxt_ref_div[7:0] = wr_data;
      end else if (addr == pdcr_pkg::ADDR_SECOND_RATIO_TOP) begin
        nxt_second[8] = wr_data[0];
      end else if (addr == pdcr_pkg::ADDR_SECOND_RATIO_LOW) begin
        nxt_second[7:0] = wr_data;
      end else if (addr == pdcr_pkg::ADDR_FIRST_STAGE_BYPASS) begin
        nxt_first_bypass = wr_data[0];
      end else if (addr == pdcr_pkg::ADDR_DOUBLER_PREDIV) begin
        nxt_doubler = wr_data[7];
        nxt_prediv  = wr_data[5:0];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // first-stage fields
  // ---------------------------------------------------------------------------
  // ratios are held exactly as written; out-of-range codes are the user's risk
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      main_feedback_ratio_out    <= pdcr_pkg::RST_MAIN_FB_RATIO;
      aux_feedback_ratio_out     <= pdcr_pkg::RST_AUX_FB_RATIO;
      reference_prediv_ratio_out <= pdcr_pkg::RST_REF_PREDIV;
      feedback_sample_phase_out  <= pdcr_pkg::RST_SAMPLE_PHASE;
      reference_sample_phase_out <= pdcr_pkg::RST_SAMPLE_PHASE;
      feedback_bypass_select_out <= pdcr_pkg::RST_BYPASS_SELECT;
    end else begin
      main_feedback_ratio_out    <= nxt_main_fb;
      aux_feedback_ratio_out     <= nxt_aux_fb;
      reference_prediv_ratio_out <= nxt_ref_div;
      feedback_sample_phase_out  <= nxt_fb_phase;
      reference_sample_phase_out <= nxt_ref_phase;
      feedback_bypass_select_out <= nxt_fb_bypass;
    end
  end

  // auxiliary divider power state; enable kept as its own flop for the divider
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      aux_feedback_powerdown_out <= pdcr_pkg::RST_AUX_POWERDOWN;
      aux_divider_enable_out     <= ~pdcr_pkg::RST_AUX_POWERDOWN;
    end else begin
      aux_feedback_powerdown_out <= nxt_aux_pd;
      aux_divider_enable_out     <= ~nxt_aux_pd;
    end
  end

  // ---------------------------------------------------------------------------
  // second-stage fields
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      second_stage_ratio_out        <= pdcr_pkg::RST_SECOND_RATIO;
      second_stage_prediv_out       <= pdcr_pkg::RST_SECOND_PREDIV;
      frequency_doubler_select_out  <= pdcr_pkg::RST_DOUBLER_SELECT;
      first_stage_bypass_select_out <= pdcr_pkg::RST_BYPASS_SELECT;
    end else begin
      second_stage_ratio_out        <= nxt_second;
      second_stage_prediv_out       <= nxt_prediv;
      frequency_doubler_select_out  <= nxt_doubler;
      first_stage_bypass_select_out <= nxt_first_bypass;
    end
  end

  // prediv counts only with doubler off and a non-bypass code
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      second_prediv_active_out <= 1'b0;
    end else begin
      second_prediv_active_out <= ~nxt_doubler &&
                                  (nxt_prediv != pdcr_pkg::PREDIV_BYPASS_CODE);
    end
  end

  // one-cycle marker so divider counters reload the new ratio
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ratio_update_out <= 1'b0;
    end else begin
      ratio_update_out <= wr_en;
    end
  end

  // ---------------------------------------------------------------------------
  // readback, reserved bits and unmapped addresses read as zero
  // ---------------------------------------------------------------------------
  always_comb begin
    rd_data = pdcr_pkg::READ_UNMAPPED;
    if (addr == pdcr_pkg::ADDR_FB_PHASE_PD_RATIO_HIGH) begin
      rd_data = {feedback_sample_phase_out, aux_feedback_powerdown_out,
                 main_feedback_ratio_out[11:8]};
    end else if (addr == pdcr_pkg::ADDR_FB_RATIO_LOW) begin
      rd_data = main_feedback_ratio_out[7:0];
    end else if (addr == pdcr_pkg::ADDR_AUX_FB_RATIO_LOW) begin
      rd_data = aux_feedback_ratio_out[7:0];
    end else if (addr == pdcr_pkg::ADDR_AUX_FB_RATIO_TOP_BYPASS) begin
      rd_data = {aux_feedback_ratio_out[8], 6'h00, feedback_bypass_select_out};
    end else if (addr == pdcr_pkg::ADDR_REF_PHASE_RATIO_HIGH) begin
      rd_data = {reference_sample_phase_out, 1'b0, reference_prediv_ratio_out[11:8]};
    end else if (addr == pdcr_pkg::ADDR_REF_RATIO_LOW) begin
      rd_data = reference_prediv_ratio_out[7:0];
    end else if (addr == pdcr_pkg::ADDR_SECOND_RATIO_TOP) begin
      rd_data = {7'h00, second_stage_ratio_out[8]};
    end else if (addr == pdcr_pkg::ADDR_SECOND_RATIO_LOW) begin
      rd_data = second_stage_ratio_out[7:0];
    end else if (addr == pdcr_pkg::ADDR_FIRST_STAGE_BYPASS) begin
      rd_data = {7'h00, first_stage_bypass_select_out};
    end else if (addr == pdcr_pkg::ADDR_DOUBLER_PREDIV) begin
      rd_data = {frequency_doubler_select_out, 1'b0, second_stage_prediv_out};
    end
  end

endmodule // pdcr_regs

/* rtl/pdcr_pkg.sv */
// Purpose : shared constants for the pll divider configuration register bank
// Assumes : 8-bit registers, 7-bit register address on the serial port
// Notes   : reset values are the power-on divider ratios of both pll stages

package pdcr_pkg;

  // ---------------------------------------------------------------------------
  // register addresses
  // ---------------------------------------------------------------------------
  localparam logic [6:0] ADDR_FB_PHASE_PD_RATIO_HIGH  = 7'h00;
  localparam logic [6:0] ADDR_FB_RATIO_LOW            = 7'h01;
  localparam logic [6:0] ADDR_AUX_FB_RATIO_LOW        = 7'h02;
  localparam logic [6:0] ADDR_AUX_FB_RATIO_TOP_BYPASS = 7'h03;
  localparam logic [6:0] ADDR_REF_PHASE_RATIO_HIGH    = 7'h04;
  localparam logic [6:0] ADDR_REF_RATIO_LOW           = 7'h05;
  localparam logic [6:0] ADDR_SECOND_RATIO_TOP        = 7'h08;
  localparam logic [6:0] ADDR_SECOND_RATIO_LOW        = 7'h09;
  localparam logic [6:0] ADDR_FIRST_STAGE_BYPASS      = 7'h0a;
  localparam logic [6:0] ADDR_DOUBLER_PREDIV          = 7'h0c;

  // ---------------------------------------------------------------------------
  // field reset values
  // ---------------------------------------------------------------------------
  localparam logic [11:0] RST_MAIN_FB_RATIO   = 12'hc00;  // divide by 3072
  localparam logic [8:0]  RST_AUX_FB_RATIO    = 9'h060;   // divide by 96
  localparam logic [11:0] RST_REF_PREDIV      = 12'hc00;  // divide by 3072
  localparam logic [8:0]  RST_SECOND_RATIO    = 9'h018;   // divide by 24
  localparam logic [5:0]  RST_SECOND_PREDIV   = 6'h00;    // bypass code
  localparam logic [2:0]  RST_SAMPLE_PHASE    = 3'h0;
  localparam logic        RST_AUX_POWERDOWN   = 1'b0;
  localparam logic        RST_DOUBLER_SELECT  = 1'b0;
  localparam logic        RST_BYPASS_SELECT   = 1'b0;
  localparam logic [5:0]  PREDIV_BYPASS_CODE  = 6'h00;
  localparam logic [7:0]  READ_UNMAPPED       = 8'h00;

  // ---------------------------------------------------------------------------
  // serial frame layout: rw bit, 7 address bits, 8 data bits, msb first
  // ---------------------------------------------------------------------------
  localparam logic [4:0] SPI_HDR_BITS   = 5'd8;
  localparam logic [4:0] SPI_FRAME_BITS = 5'd16;
  localparam logic       SPI_RW_READ    = 1'b1;

  typedef enum logic [1:0] {
    PDCR_SPI_HDR,
    PDCR_SPI_DATA,
    PDCR_SPI_DONE
  } pdcr_spi_state_t;

endpackage

/* rtl/pdcr_spi_port.sv */
// Purpose : three-wire serial configuration port, sampled in the clk_in domain
// Assumes : sclk, csn and sdio are synchronous to clk_in; sclk phases last >= 2 clocks
// Notes   : data captured on sclk rise, read data launched on sclk fall

`timescale 1ns/1ns

module pdcr_spi_port (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       sclk_in,
  input  wire logic       csn_in,
  input  wire logic       sdio_in,
  input  wire logic [7:0] rd_data_in,
  output logic            sdio_out,
  output logic            sdio_oe_out,
  output logic            wr_en_out,
  output logic [6:0]      addr_out,
  output logic [7:0]      wr_data_out
);

  // ---------------------------------------------------------------------------
  // frame sequencing
  // ---------------------------------------------------------------------------
  pdcr_pkg::pdcr_spi_state_t state_ff;
  logic                      sclk_prev_ff;
  logic [4:0]                bit_cnt_ff;
  logic [7:0]                shift_ff;
  logic [7:0]                rd_shift_ff;
  logic                      read_ff;
  logic                      sclk_rise;
  logic                      sclk_fall;

  assign sclk_rise = sclk_in & ~sclk_prev_ff;
  assign sclk_fall = ~sclk_in & sclk_prev_ff;

  // edge history of the serial clock
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sclk_prev_ff <= 1'b0;
    end else begin
      sclk_prev_ff <= sclk_in;
    end
  end

  // bit counter and state; deselect always aborts a partial frame
  always_ff @(posedge clk_in) begin
    if (rst_in || csn_in) begin
      state_ff   <= pdcr_pkg::PDCR_SPI_HDR;
      bit_cnt_ff <= 5'd0;
    end else if (sclk_rise) begin
      bit_cnt_ff <= bit_cnt_ff + 5'd1;
      case (state_ff)
        pdcr_pkg::PDCR_SPI_HDR: begin
          if (bit_cnt_ff + 5'd1 == pdcr_pkg::SPI_HDR_BITS) begin
            state_ff <= pdcr_pkg::PDCR_SPI_DATA;
          end
        end
        pdcr_pkg::PDCR_SPI_DATA: begin
          if (bit_cnt_ff + 5'd1 == pdcr_pkg::SPI_FRAME_BITS) begin
            state_ff <= pdcr_pkg::PDCR_SPI_DONE;
          end
        end
        default: begin
          state_ff <= pdcr_pkg::PDCR_SPI_DONE;  // extra clocks ignored
        end
      endcase
    end
  end

  // input shifter, header latch and write strobe
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      shift_ff    <= 8'h00;
      read_ff     <= 1'b0;
      addr_out    <= 7'h00;
      wr_en_out   <= 1'b0;
      wr_data_out <= 8'h00;
    end else begin
      wr_en_out <= 1'b0;
      if (!csn_in && sclk_rise && state_ff != pdcr_pkg::PDCR_SPI_DONE) begin
        shift_ff <= {shift_ff[6:0], sdio_in};
        if (state_ff == pdcr_pkg::PDCR_SPI_HDR &&
            bit_cnt_ff + 5'd1 == pdcr_pkg::SPI_HDR_BITS) begin
          read_ff  <= (shift_ff[6] == pdcr_pkg::SPI_RW_READ);
          addr_out <= {shift_ff[5:0], sdio_in};
        end
        if (state_ff == pdcr_pkg::PDCR_SPI_DATA &&
            bit_cnt_ff + 5'd1 == pdcr_pkg::SPI_FRAME_BITS) begin
          wr_en_out   <= ~read_ff;
          wr_data_out <= {shift_ff[6:0], sdio_in};
        end
      end
    end
  end

  // read data driven back on the shared pin, one bit per falling edge
  always_ff @(posedge clk_in) begin
    if (rst_in || csn_in) begin
      rd_shift_ff <= 8'h00;
      sdio_out    <= 1'b0;
      sdio_oe_out <= 1'b0;
    end else if (sclk_fall && state_ff == pdcr_pkg::PDCR_SPI_DATA && read_ff) begin
      sdio_oe_out <= 1'b1;
      if (bit_cnt_ff == pdcr_pkg::SPI_HDR_BITS) begin
        sdio_out    <= rd_data_in[7];
        rd_shift_ff <= {rd_data_in[6:0], 1'b0};
      end else begin
        sdio_out    <= rd_shift_ff[7];
        rd_shift_ff <= {rd_shift_ff[6:0], 1'b0};
      end
    end else if (state_ff == pdcr_pkg::PDCR_SPI_DONE && sclk_fall) begin
      sdio_oe_out <= 1'b0;  // release the pin after the last data bit
    end
  end

endmodule // pdcr_spi_port

/* dv/pdcr_regs_checker.sv */
// Purpose : concurrent checks on the pll divider register bank ports
// Assumes : one clock domain, synchronous active-high reset
// Notes   : bound to pdcr_regs below the module
`timescale 1ns/1ns

module pdcr_regs_checker (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        spi_csn_in,
  input  wire logic        spi_sdio_oe_out,
  input  wire logic [11:0] main_feedback_ratio_out,
  input  wire logic [8:0]  aux_feedback_ratio_out,
  input  wire logic        aux_feedback_powerdown_out,
  input  wire logic        aux_divider_enable_out,
  input  wire logic [2:0]  feedback_sample_phase_out,
  input  wire logic [11:0] reference_prediv_ratio_out,
  input  wire logic [2:0]  reference_sample_phase_out,
  input  wire logic [8:0]  second_stage_ratio_out,
  input  wire logic [5:0]  second_stage_prediv_out,
  input  wire logic        frequency_doubler_select_out,
  input  wire logic        second_prediv_active_out,
  input  wire logic        ratio_update_out
);
  // -------------------------------------------------------------------------
  // clocking and step sequences
  // -------------------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // any ratio, second-stage prediv or doubler select field moving at this edge
  sequence s_field_moves;
    $changed(main_feedback_ratio_out) || $changed(aux_feedback_ratio_out) ||
    $changed(reference_prediv_ratio_out) || $changed(second_stage_ratio_out) ||
    $changed(second_stage_prediv_out) || $changed(frequency_doubler_select_out);
  endsequence
  // first edge out of reset
  sequence s_reset_left;
    $fell(rst_in);
  endsequence

  // -------------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------------
  a_main_ratio_default: assert property (s_reset_left |-> main_feedback_ratio_out == 12'hc00)
    else $error("main ratio not at default after reset");
  a_aux_ratio_default: assert property (s_reset_left |-> aux_feedback_ratio_out == 9'h060)
    else $error("aux ratio not at default after reset");
  a_ref_ratio_default: assert property (s_reset_left |-> reference_prediv_ratio_out == 12'hc00 && reference_sample_phase_out == 3'h0 && feedback_sample_phase_out == 3'h0)
    else $error("reference fields not at default after reset");
  a_second_stage_default: assert property (s_reset_left |-> second_stage_ratio_out == 9'h018 && second_stage_prediv_out == 6'h00 && !frequency_doubler_select_out)
    else $error("second stage fields not at default after reset");
  a_aux_enable_tracks: assert property (aux_divider_enable_out == !aux_feedback_powerdown_out)
    else $error("aux enable disagrees with power-down");
  // derived flag may lag its fields by the update cycle only
  a_prediv_active_rel: assert property (!ratio_update_out |-> second_prediv_active_out == (!frequency_doubler_select_out && second_stage_prediv_out != 6'h00))
    else $error("prediv active flag wrong");
  a_field_needs_update: assert property (s_field_moves |-> ratio_update_out)
    else $error("field changed without update pulse");
  a_update_single_pulse: assert property (ratio_update_out |=> !ratio_update_out)
    else $error("update pulse longer than one cycle");
  a_update_from_frame: assert property (ratio_update_out |-> $past(spi_csn_in, 2) == 1'b0)
    else $error("update pulse without a selected frame");
  a_oe_idle_released: assert property (spi_csn_in [*2] |-> !spi_sdio_oe_out)
    else $error("data pin driven while deselected");
endmodule // pdcr_regs_checker

bind pdcr_regs pdcr_regs_checker u_pdcr_regs_checker (
  .clk_in(clk_in), .rst_in(rst_in), .spi_csn_in(spi_csn_in),
  .spi_sdio_oe_out(spi_sdio_oe_out), .main_feedback_ratio_out(main_feedback_ratio_out),
  .aux_feedback_ratio_out(aux_feedback_ratio_out),
  .aux_feedback_powerdown_out(aux_feedback_powerdown_out),
  .aux_divider_enable_out(aux_divider_enable_out),
  .feedback_sample_phase_out(feedback_sample_phase_out),
  .reference_prediv_ratio_out(reference_prediv_ratio_out),
  .reference_sample_phase_out(reference_sample_phase_out),
  .second_stage_ratio_out(second_stage_ratio_out),
  .second_stage_prediv_out(second_stage_prediv_out),
  .frequency_doubler_select_out(frequency_doubler_select_out),
  .second_prediv_active_out(second_prediv_active_out), .ratio_update_out(ratio_update_out));

/* dv/pdcr_regs_tb.sv */
// Purpose : register-level test of the pll divider register bank
// Assumes : serial frames of rw, 7 address and 8 data bits, msb first
// Notes   : every sclk phase lasts two clocks, inputs move 1 ns after the edge
`timescale 1ns/1ns

module pdcr_regs_tb;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        sclk   = 1'b0;
  logic        csn    = 1'b1;
  logic        sdi    = 1'b0;
  logic        so, soe, apd, aen, fbb, fsb, dbl, act, upd;
  logic [11:0] mfr, rfr;
  logic [8:0]  afr, ssr;
  logic [5:0]  spd;
  logic [2:0]  fph, rph;
  logic [7:0]  r;
  int          failures = 0;
  int          samples_checked = 0;
  int          upd_cnt = 0;
  int          u0;
  // register reset images, reserved bits read back as zero
  logic [6:0]  ra [10] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h08, 7'h09, 7'h0a, 7'h0c};
  logic [7:0]  rv [10] = '{8'h0c, 8'h00, 8'h60, 8'h00, 8'h0c, 8'h00, 8'h00, 8'h18, 8'h00, 8'h00};

  always #4 clk_in = ~clk_in;
  // count update pulses independently of any frame task
  always @(posedge clk_in) if (upd === 1'b1) upd_cnt <= upd_cnt + 1;

  pdcr_regs u_pdcr_regs (.clk_in(clk_in), .rst_in(rst_in), .spi_sclk_in(sclk),
    .spi_csn_in(csn), .spi_sdio_in(sdi), .spi_sdio_out(so), .spi_sdio_oe_out(soe),
    .main_feedback_ratio_out(mfr), .aux_feedback_ratio_out(afr),
    .aux_feedback_powerdown_out(apd), .aux_divider_enable_out(aen),
    .feedback_sample_phase_out(fph), .feedback_bypass_select_out(fbb),
    .reference_prediv_ratio_out(rfr), .reference_sample_phase_out(rph),
    .second_stage_ratio_out(ssr), .first_stage_bypass_select_out(fsb),
    .second_stage_prediv_out(spd), .frequency_doubler_select_out(dbl),
    .second_prediv_active_out(act), .ratio_update_out(upd));

  // -------------------------------------------------------------------------
  // access tasks
  // -------------------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // nb below 16 raises select early, which must discard the frame
  task automatic frame(input logic rw, input logic [6:0] a, input logic [7:0] d,
                       input int nb, output logic [7:0] q);
    logic [15:0] w;
    w = {rw, a, d};
    q = 8'h00;
    csn = 1'b0;
    step(1);
    for (int i = 0; i < nb; i++) begin
      sdi = w[15-i];
      sclk = 1'b1;
      step(2);
      if (i >= 8) q[15-i] = so;
      sclk = 1'b0;
      step(2);
    end
    csn = 1'b1;
    sdi = 1'b0;
    step(2);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    u0 = upd_cnt;
    frame(1'b0, a, d, 16, r);
    chk(12'(upd_cnt - u0), 12'h001);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    frame(1'b1, a, 8'h00, 16, r);
    chk(12'(r), 12'(exp));
  endtask
  task automatic chk_reset;
    for (int i = 0; i < 10; i++) rd(ra[i], rv[i]);
    chk(mfr, 12'hc00);
    chk(12'(afr), 12'h060);
    chk(12'({apd, aen}), 12'h001);
    chk(rfr, 12'hc00);
    chk(12'(ssr), 12'h018);
    chk(12'({spd, dbl, act}), 12'h000);
    chk(12'({fph, rph}), 12'h000);
  endtask
  task automatic end_sim;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // -------------------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------------------
  initial begin
    step(3);
    rst_in = 1'b0;
    step(1);
    chk_reset();
    $display("test reset_defaults done");
    wr(7'h00, 8'hff);
    wr(7'h01, 8'hff);
    chk(mfr, 12'hfff);
    chk(12'({fph, apd, aen}), 12'h01e);
    rd(7'h00, 8'hff);
    wr(7'h00, 8'h40);
    wr(7'h01, 8'h20);
    chk(12'({fph, apd, aen, mfr[3:0]}), 12'h090);
    chk(mfr, 12'h020);
    wr(7'h03, 8'h81);
    wr(7'h02, 8'hff);
    chk(12'({fbb, afr}), 12'h3ff);
    rd(7'h03, 8'h81);
    wr(7'h03, 8'h00);
    wr(7'h02, 8'h04);
    chk(12'({fbb, afr}), 12'h004);
    wr(7'h04, 8'hff);
    wr(7'h05, 8'hff);
    chk(rfr, 12'hfff);
    chk(12'(rph), 12'h007);
    rd(7'h04, 8'hef);
    $display("test first_stage_fields done");
    wr(7'h08, 8'hff);
    wr(7'h09, 8'hff);
    chk(12'(ssr), 12'h1ff);
    rd(7'h08, 8'h01);
    wr(7'h08, 8'h00);
    wr(7'h09, 8'h08);
    chk(12'(ssr), 12'h008);
    wr(7'h0a, 8'hff);
    rd(7'h0a, 8'h01);
    chk(12'(fsb), 12'h001);
    wr(7'h0c, 8'hff);
    rd(7'h0c, 8'hbf);
    chk(12'({spd, dbl, act}), 12'h0fe);
    wr(7'h0c, 8'h3f);
    chk(12'({spd, dbl, act}), 12'h0fd);
    wr(7'h0c, 8'h00);
    chk(12'({spd, dbl, act}), 12'h000);
    $display("test second_stage_fields done");
    u0 = upd_cnt;
    frame(1'b0, 7'h09, 8'haa, 10, r);
    chk(12'(upd_cnt - u0), 12'h000);
    chk(12'(ssr), 12'h008);
    frame(1'b0, 7'h07, 8'hff, 16, r);
    rd(7'h07, 8'h00);
    rd(7'h06, 8'h00);
    $display("test abort_unmapped done");
    rst_in = 1'b1;
    step(3);
    rst_in = 1'b0;
    step(1);
    chk_reset();
    $display("test second_reset done");
    end_sim();
  end
  // hang guard
  initial begin
    step(20000);
    failures++;
    end_sim();
  end
endmodule // pdcr_regs_tb
